// ==== hw/ofr_pkg.sv ====
/*
   Package of the option and peripheral flag register bank: register
   indices and byte addresses, field positions, reset values and the
   packed carriers that the bank, its checker and its bench share.
   Assumes a 32-bit APB with byte addresses of twelve bits.
*/
package ofr_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int FLAG_N = 4;
   localparam int LATCH_N = 6;
   localparam logic [ADDR_W-1:0] FLAGS_IDX = 12'h00C;
   localparam logic [ADDR_W-1:0] OPTION_IDX = 12'h081;
   localparam logic [ADDR_W-1:0] STATUS_IDX = 12'h082;
   localparam logic [ADDR_W-1:0] MASK_IDX = 12'h083;
   localparam logic [ADDR_W-1:0] FLAGS_ADDR = ADDR_W'(FLAGS_IDX * 4);
   localparam logic [ADDR_W-1:0] OPTION_ADDR = ADDR_W'(OPTION_IDX * 4);
   localparam logic [ADDR_W-1:0] STATUS_ADDR = ADDR_W'(STATUS_IDX * 4);
   localparam logic [ADDR_W-1:0] MASK_ADDR = ADDR_W'(MASK_IDX * 4);

   // ************************************************************
   // Field layout and reset values
   // ************************************************************
   localparam int POS_WIDE_TIMER = 0;
   localparam int POS_COMPARATOR = 3;
   localparam int POS_CONVERSION = 6;
   localparam int POS_NVM_WRITE = 7;
   localparam int FLAG_POS [FLAG_N] = '{POS_WIDE_TIMER, POS_COMPARATOR, POS_CONVERSION, POS_NVM_WRITE};
   localparam logic [7:0] OPTION_RESET = 8'hFF;
   localparam logic [FLAG_N-1:0] FLAGS_RESET = 4'h0;
   localparam logic [FLAG_N-1:0] MASK_RESET = 4'h0;
   localparam logic [7:0] RATE_TIMER_BASE = 8'hFF;
   localparam logic [7:0] RATE_WATCHDOG_BASE = 8'h7F;
   localparam logic [2:0] RATE_TOP = 3'h7;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic pullupDisable;
      logic extIrqEdgeSelect;
      logic tickTimerClockSource;
      logic tickTimerEdgeSelect;
      logic prescalerAssign;
      logic [2:0] prescalerRate;
   } ofr_option_t;

   // Event order: wide timer, comparator, conversion, nvm write.
   typedef struct packed {
      logic nvmWriteDone;
      logic conversionDone;
      logic comparatorChange;
      logic wideTimerOverflow;
   } ofr_events_t;

   // ************************************************************
   // Packing of the four flags into their byte positions
   // ************************************************************
   function automatic logic [7:0] ofr_spread(input logic [FLAG_N-1:0] bits);
      logic [7:0] b;
      b = 8'h00;
      for (int i = 0; i < FLAG_N; i++) begin
         b[FLAG_POS[i]] = bits[i];
      end
      return b;
   endfunction

   function automatic logic [FLAG_N-1:0] ofr_gather(input logic [7:0] b);
      logic [FLAG_N-1:0] bits;
      bits = '0;
      for (int i = 0; i < FLAG_N; i++) begin
         bits[i] = b[FLAG_POS[i]];
      end
      return bits;
   endfunction

endpackage

// ==== hw/ofr_sticky_bit.sv ====
/*
   One sticky flag cell. A hardware set, a software set and a software
   clear may arrive in one cycle; the set always wins.
   Assumes all inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
module ofr_sticky_bit
   import ofr_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic resetValue,
   input wire logic hwSet,
   input wire logic swSet,
   input wire logic swClear,
   output logic flag
);

   logic flag_reg;
   logic flag_next;

   // A set in the same cycle as a clear keeps the flag.
   assign flag_next = hwSet | swSet | (flag_reg & ~swClear);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flag_reg <= 1'b0;
      end else if (ce) begin
         flag_reg <= flag_next;
      end
   end

   assign flag = flag_reg;

endmodule

// ==== hw/ofr_option_flag_regs.sv ====
/*
   Option register and peripheral interrupt flag register of a small
   controller core, reached over APB, with the logic the option bits
   steer: pull-up enables, external interrupt edge, tick timer source
   and edge, and the prescaler shared by tick timer and watchdog.
   Assumes event inputs are one-cycle pulses on the same clock and that
   the external interrupt and timer clock pins are asynchronous.
*/
`timescale 1ns/1ps
module ofr_option_flag_regs
   import ofr_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [LATCH_N-1:0] portLatch,
   input wire logic extIrqPin,
   input wire logic tickTimerClockPin,
   input wire logic instructionCycleClock,
   input wire logic watchdogRawTick,
   input wire ofr_events_t events,
   output ofr_option_t option,
   output logic [LATCH_N-1:0] pullupEnable,
   output logic extIrqEvent,
   output logic tickTimerIncrement,
   output logic watchdogTick,
   output logic irq
);

   // ************************************************************
   // APB decode
   // ************************************************************
   logic [DATA_W-1:0] prdata_reg;
   logic [DATA_W-1:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic selFlags;
   logic selOption;
   logic selStatus;
   logic selMask;
   logic mapped;
   logic accessPhase;
   logic commit;
   logic writeByte;
   logic [7:0] wrData;
   logic [7:0] readByte;

   assign selFlags = (paddr == FLAGS_ADDR);
   assign selOption = (paddr == OPTION_ADDR);
   assign selStatus = (paddr == STATUS_ADDR);
   assign selMask = (paddr == MASK_ADDR);
   assign mapped = selFlags | selOption | selStatus | selMask;
   assign accessPhase = psel & penable;
   // The answer comes one cycle into the access phase; writes land then.
   assign commit = accessPhase & pready_reg;
   assign writeByte = commit & pwrite & mapped & pstrb[0];
   assign wrData = pwdata[7:0];
   assign pready_next = accessPhase & ~pready_reg;
   assign pslverr_next = accessPhase & ~pready_reg & ~mapped;

   // ************************************************************
   // Option register
   // ************************************************************
   ofr_option_t option_reg;
   ofr_option_t option_next;
   logic optionWrite;

   assign optionWrite = writeByte & selOption;
   assign option_next = optionWrite ? ofr_option_t'(wrData) : option_reg;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         option_reg <= ofr_option_t'(OPTION_RESET);
      end else if (ce) begin
         option_reg <= option_next;
      end
   end

   assign option = option_reg;

   // ************************************************************
   // Peripheral flags and interrupt status
   // ************************************************************
   logic [FLAG_N-1:0] eventVec;
   logic [FLAG_N-1:0] flagBits;
   logic [FLAG_N-1:0] statusBits;
   logic [FLAG_N-1:0] wrBits;
   logic flagsWrite;
   logic statusWrite;
   logic maskWrite;
   logic [FLAG_N-1:0] mask_reg;
   logic [FLAG_N-1:0] mask_next;
   logic irq_reg;
   logic irq_next;

   // Events set flags without regard to the interrupt mask.
   assign eventVec = events;
   assign wrBits = ofr_gather(wrData);
   assign flagsWrite = writeByte & selFlags;
   assign statusWrite = writeByte & selStatus;
   assign maskWrite = writeByte & selMask;

   genvar gi;
   generate
      for (gi = 0; gi < FLAG_N; gi++) begin : gFlag
         // Flag cell: software writes the value, zero clears.
         ofr_sticky_bit uFlag (
            .clock(clock),
            .rst(rst),
            .ce(ce),
            .resetValue(FLAGS_RESET[gi]),
            .hwSet(eventVec[gi]),
            .swSet(flagsWrite & wrBits[gi]),
            .swClear(flagsWrite & ~wrBits[gi]),
            .flag(flagBits[gi])
         );
         // Status cell: writing a one clears it.
         ofr_sticky_bit uStatus (
            .clock(clock),
            .rst(rst),
            .ce(ce),
            .resetValue(FLAGS_RESET[gi]),
            .hwSet(eventVec[gi]),
            .swSet(1'b0),
            .swClear(statusWrite & wrBits[gi]),
            .flag(statusBits[gi])
         );
      end
   endgenerate

   assign mask_next = maskWrite ? wrBits : mask_reg;
   assign irq_next = |(statusBits & mask_reg);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mask_reg <= MASK_RESET;
         irq_reg <= 1'b0;
      end else if (ce) begin
         mask_reg <= mask_next;
         irq_reg <= irq_next;
      end
   end

   assign irq = irq_reg;

   // ************************************************************
   // Read path
   // ************************************************************
   // Unimplemented flag positions are never stored and read as zero.
   assign readByte = selOption ? option_reg :
                     selFlags ? ofr_spread(flagBits) :
                     selStatus ? ofr_spread(statusBits) :
                     selMask ? ofr_spread(mask_reg) :
                     8'h00;
   assign prdata_next = (pready_next & ~pwrite) ? {24'h000000, readByte} : prdata_reg;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else if (ce) begin
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [1:0] irqPinSync_reg;
   logic [1:0] clkPinSync_reg;
   logic irqPinLast_reg;
   logic clkPinLast_reg;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irqPinSync_reg <= 2'b00;
         clkPinSync_reg <= 2'b00;
         irqPinLast_reg <= 1'b0;
         clkPinLast_reg <= 1'b0;
      end else if (ce) begin
         irqPinSync_reg <= {irqPinSync_reg[0], extIrqPin};
         clkPinSync_reg <= {clkPinSync_reg[0], tickTimerClockPin};
         irqPinLast_reg <= irqPinSync_reg[1];
         clkPinLast_reg <= clkPinSync_reg[1];
      end
   end

   // ************************************************************
   // External interrupt edge and pull-ups
   // ************************************************************
   logic irqRise;
   logic irqFall;
   logic extIrqEvent_reg;
   logic extIrqEvent_next;
   logic [LATCH_N-1:0] pullupEnable_reg;
   logic [LATCH_N-1:0] pullupEnable_next;

   assign irqRise = irqPinSync_reg[1] & ~irqPinLast_reg;
   assign irqFall = ~irqPinSync_reg[1] & irqPinLast_reg;
   assign extIrqEvent_next = option_reg.extIrqEdgeSelect ? irqRise : irqFall;
   assign pullupEnable_next = option_reg.pullupDisable ? '0 : portLatch;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         extIrqEvent_reg <= 1'b0;
         pullupEnable_reg <= '0;
      end else if (ce) begin
         extIrqEvent_reg <= extIrqEvent_next;
         pullupEnable_reg <= pullupEnable_next;
      end
   end

   assign extIrqEvent = extIrqEvent_reg;
   assign pullupEnable = pullupEnable_reg;

   // ************************************************************
   // Tick timer source
   // ************************************************************
   logic clkRise;
   logic clkFall;
   logic pinTick;
   logic sourceTick;

   assign clkRise = clkPinSync_reg[1] & ~clkPinLast_reg;
   assign clkFall = ~clkPinSync_reg[1] & clkPinLast_reg;
   assign pinTick = option_reg.tickTimerEdgeSelect ? clkFall : clkRise;
   assign sourceTick = option_reg.tickTimerClockSource ? pinTick : instructionCycleClock;

   // ************************************************************
   // Shared prescaler
   // ************************************************************
   logic [7:0] prescale_reg;
   logic [7:0] prescale_next;
   logic [7:0] prescaleLimit;
   logic [2:0] limitShift;
   logic toWatchdog;
   logic prescaleIn;
   logic prescaleWrap;
   logic assignChange;
   logic tickInc_reg;
   logic tickInc_next;
   logic wdTick_reg;
   logic wdTick_next;

   assign toWatchdog = option_reg.prescalerAssign;
   assign limitShift = RATE_TOP - option_reg.prescalerRate;
   // Timer ratio is 2^(rate+1), watchdog ratio is 2^rate.
   assign prescaleLimit = toWatchdog ? (RATE_WATCHDOG_BASE >> limitShift) :
                                       (RATE_TIMER_BASE >> limitShift);
   assign prescaleIn = toWatchdog ? watchdogRawTick : sourceTick;
   // A count left at or above a lowered limit wraps on its next input instead of running round.
   assign prescaleWrap = prescaleIn & (prescale_reg >= prescaleLimit);
   // A change of owner restarts the count so neither side sees a short period.
   assign assignChange = optionWrite & (wrData[3] != option_reg.prescalerAssign);
   assign prescale_next = assignChange ? 8'h00 :
                          prescaleWrap ? 8'h00 :
                          prescaleIn ? prescale_reg + 8'h01 :
                          prescale_reg;
   // The timer bypasses the prescaler only while the watchdog owns it.
   assign tickInc_next = toWatchdog ? sourceTick : prescaleWrap;
   assign wdTick_next = toWatchdog ? prescaleWrap : watchdogRawTick;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prescale_reg <= 8'h00;
         tickInc_reg <= 1'b0;
         wdTick_reg <= 1'b0;
      end else if (ce) begin
         prescale_reg <= prescale_next;
         tickInc_reg <= tickInc_next;
         wdTick_reg <= wdTick_next;
      end
   end

   assign tickTimerIncrement = tickInc_reg;
   assign watchdogTick = wdTick_reg;

endmodule

// ==== test/ofr_option_flag_regs_sva.sv ====
/*
   Checker of the option and flag register bank, watching its ports only.
   Assumes one clock domain and ce held high.
*/
`timescale 1ns/1ps
module ofr_option_flag_regs_sva
   import ofr_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [LATCH_N-1:0] portLatch,
   input wire logic extIrqPin,
   input wire logic tickTimerClockPin,
   input wire logic instructionCycleClock,
   input wire logic watchdogRawTick,
   input wire ofr_events_t events,
   input wire ofr_option_t option,
   input wire logic [LATCH_N-1:0] pullupEnable,
   input wire logic extIrqEvent,
   input wire logic tickTimerIncrement,
   input wire logic watchdogTick,
   input wire logic irq
);
   // ************************************************************
   // Properties
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence sAccessStart;
      psel && penable && !$past(psel && penable);
   endsequence
   sequence sOptWrite;
      psel && penable && pready && pwrite && pstrb[0] && paddr == OPTION_ADDR;
   endsequence
   a_pready_wait: assert property (sAccessStart |=> pready)
      else $error("pready late");
   a_option_write: assert property (sOptWrite |=> option == ofr_option_t'($past(pwdata[7:0])))
      else $error("option write lost");
   a_option_hold: assert property (!$stable(option) |-> $past(psel && penable && pready && pwrite))
      else $error("option changed without write");
   a_pullup_follow: assert property (!option.pullupDisable |=> pullupEnable == $past(portLatch))
      else $error("pull-ups do not follow latches");
   a_pullup_off: assert property (option.pullupDisable |=> pullupEnable == '0)
      else $error("pull-ups not disabled");
   a_wdt_direct: assert property (!option.prescalerAssign && watchdogRawTick |=> watchdogTick)
      else $error("watchdog tick lost");
   a_wdt_bypass: assert property (option.prescalerAssign && option.prescalerRate == 3'h0 && watchdogRawTick
      |=> watchdogTick)
      else $error("watchdog 1:1 lost");
   a_timer_bypass: assert property (option.prescalerAssign && !option.tickTimerClockSource
      && instructionCycleClock |=> tickTimerIncrement)
      else $error("timer not undivided");
   a_timer_div: assert property (tickTimerIncrement && !$past(option.prescalerAssign)
      && !$past(option.prescalerAssign, 2) |-> !$past(tickTimerIncrement))
      else $error("timer prescaled 1:1");
   a_flag_zero: assert property (pready && !pwrite && paddr == FLAGS_ADDR
      |-> prdata[5:4] == 2'h0 && prdata[2:1] == 2'h0)
      else $error("unimplemented flag bits set");
endmodule

bind ofr_option_flag_regs ofr_option_flag_regs_sva chk (.clock, .rst, .ce, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .pready, .pslverr, .portLatch, .extIrqPin, .tickTimerClockPin,
   .instructionCycleClock, .watchdogRawTick, .events, .option, .pullupEnable, .extIrqEvent,
   .tickTimerIncrement, .watchdogTick, .irq);

// ==== test/test_ofr_option_flag_regs.sv ====
/*
   Self-checking bench of the option and flag register bank.
   Assumes the bank answers APB with its own pready.
*/
`timescale 1ns/1ps
module test_ofr_option_flag_regs
   import ofr_pkg::*;
;
   logic clock = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic [LATCH_N-1:0] portLatch = '0, pullupEnable;
   logic extIrqPin = 0, tickTimerClockPin = 0, instructionCycleClock = 0, watchdogRawTick = 0;
   logic pready, pslverr, extIrqEvent, tickTimerIncrement, watchdogTick, irq, er;
   ofr_events_t events = '0;
   ofr_option_t option;
   logic [31:0] seed = 32'h72E43F9E;
   int errCount = 0, testsRun = 0, tickCnt = 0, wdCnt = 0, extCnt = 0, t0, w0, x0;
   logic [3:0] m;
   logic [7:0] v;

   ofr_option_flag_regs uut (.clock(clock), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .portLatch(portLatch), .extIrqPin(extIrqPin), .tickTimerClockPin(tickTimerClockPin),
      .instructionCycleClock(instructionCycleClock), .watchdogRawTick(watchdogRawTick), .events(events),
      .option(option), .pullupEnable(pullupEnable), .extIrqEvent(extIrqEvent),
      .tickTimerIncrement(tickTimerIncrement), .watchdogTick(watchdogTick), .irq(irq));

   // ************************************************************
   // Helpers
   // ************************************************************
   initial begin
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      portLatch <= LATCH_N'(rnd());
      tickCnt += tickTimerIncrement;
      wdCnt += watchdogTick;
      extCnt += extIrqEvent;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] spread(input logic [3:0] b);
      return {b[3], b[2], 2'b00, b[1], 2'b00, b[0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      testsRun++;
      if (g !== e) begin
         errCount++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Events given here are held high up to the commit edge of the transfer.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] ev);
      int n;
      n = 0;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      do begin
         @(posedge clock);
         n++;
         if (pready !== 1'b1) events <= ev;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk("pready", 1, 0);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      events <= '0;
      @(posedge clock);
   endtask
   task automatic pulse(input int n, input bit wd);
      repeat (n) begin
         if (wd) watchdogRawTick <= 1;
         else instructionCycleClock <= 1;
         @(posedge clock);
         watchdogRawTick <= 0;
         instructionCycleClock <= 0;
         @(posedge clock);
      end
      repeat (4) @(posedge clock);
   endtask
   task automatic endSim();
      $display("checks %0d mismatches %0d", testsRun, errCount);
      if (errCount == 0 && testsRun > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      repeat (20000) @(posedge clock);
      errCount++;
      endSim();
   end
   initial begin
      repeat (10) @(posedge clock);
      rst <= 0;
      @(posedge clock);
      apb(0, OPTION_ADDR, 0, 0);
      chk("option reset", 32'hFF, rd);
      apb(0, FLAGS_ADDR, 0, 0);
      chk("flags reset", 32'h0, rd);
      $display("test reset done");
      for (int r = 0; r < 3; r++) begin
         apb(1, OPTION_ADDR, 32'h88 | r, 0);
         {t0, w0} = {tickCnt, wdCnt};
         pulse(3 << r, 1);
         pulse(3, 0);
         chk("wdt divided", 3, wdCnt - w0);
         chk("timer undivided", 3, tickCnt - t0);
         apb(1, OPTION_ADDR, 32'h80 | r, 0);
         {t0, w0} = {tickCnt, wdCnt};
         pulse(3 << (r + 1), 0);
         pulse(2, 1);
         chk("timer divided", 3, tickCnt - t0);
         chk("wdt direct", 2, wdCnt - w0);
      end
      $display("test prescaler done");
      for (int e = 0; e < 2; e++) begin
         apb(1, OPTION_ADDR, 32'hA8 | (e << 6) | (e << 4), 0);
         repeat (8) @(posedge clock);
         {t0, x0} = {tickCnt, extCnt};
         {extIrqPin, tickTimerClockPin} <= 2'b11;
         repeat (8) @(posedge clock);
         chk("ext rise", e, extCnt - x0);
         chk("pin rise", 1 - e, tickCnt - t0);
         {t0, x0} = {tickCnt, extCnt};
         {extIrqPin, tickTimerClockPin} <= 2'b00;
         repeat (8) @(posedge clock);
         chk("ext fall", 1 - e, extCnt - x0);
         chk("pin fall", e, tickCnt - t0);
      end
      $display("test pins done");
      repeat (6) begin
         v = rnd();
         apb(1, OPTION_ADDR, {rnd() & 32'hFFFFFF00} | v, 0);
         chk("option port", v, option);
         apb(0, OPTION_ADDR, 0, 0);
         chk("option read", v, rd);
      end
      pstrb <= 4'h0;
      apb(1, OPTION_ADDR, ~v, 0);
      pstrb <= 4'hF;
      apb(0, OPTION_ADDR, 0, 0);
      chk("option strobe", v, rd);
      $display("test option done");
      for (int i = 0; i < 4; i++) begin
         m = rnd();
         apb(1, FLAGS_ADDR, 0, 0);
         apb(1, STATUS_ADDR, 32'hFF, 0);
         apb(1, MASK_ADDR, spread(m), 0);
         events <= 4'(1 << i);
         @(posedge clock);
         events <= '0;
         repeat (3) @(posedge clock);
         chk("irq", m[i], irq);
         apb(0, FLAGS_ADDR, 0, 0);
         chk("flag set", spread(1 << i), rd);
         apb(1, FLAGS_ADDR, 0, 4'(1 << i));
         apb(0, FLAGS_ADDR, 0, 0);
         chk("set beats clear", spread(1 << i), rd);
         apb(1, FLAGS_ADDR, 0, 0);
         apb(0, FLAGS_ADDR, 0, 0);
         chk("flag clear", 0, rd);
         apb(1, STATUS_ADDR, spread(1 << i), 0);
         repeat (3) @(posedge clock);
         chk("irq clear", 0, irq);
      end
      apb(1, FLAGS_ADDR, 32'hFF, 0);
      apb(0, FLAGS_ADDR, 0, 0);
      chk("flag gaps", 32'hC9, rd);
      apb(0, 12'h100, 0, 0);
      chk("unmapped err", 1, er);
      chk("unmapped data", 0, rd);
      $display("test flags done");
      endSim();
   end
endmodule
